// ==== verilog/ascp_pkg.sv ====
package ascp_pkg;
  // ----------------------------------------
  // frame timing, counted in serial clock falls
  // ----------------------------------------
  localparam int       RES_W       = 12;
  localparam int       CNT_W       = 5;
  localparam logic [4:0] FRAME_END = 5'h10;
  localparam logic [4:0] LAST_BIT  = 5'h0F;
  localparam logic [4:0] TRACK_AFT = 5'h0D;
  localparam logic [4:0] LEAD_ZERO = 5'h04;
  localparam logic [4:0] FETCH_AT  = 5'h03;
  localparam logic [4:0] PD_LO     = 5'h02;
  localparam logic [4:0] PD_HI     = 5'h0A;
  // ----------------------------------------
  // full power-down wake time
  // ----------------------------------------
  localparam int       CLK_MHZ     = 25;
  localparam int       WAKE_US     = 650;
  localparam int       WAKE_CYC    = WAKE_US * CLK_MHZ;
  localparam int       WAKE_W      = 15;
  localparam int       FIFO_D      = 4;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    PM_NORMAL  = 3'b001,
    PM_PARTIAL = 3'b010,
    PM_FULL    = 3'b100
  } ascp_pmode_t;

  typedef struct packed {
    logic dout;
    logic oe;
  } ascp_link_t;

  typedef struct packed {
    logic              cs_s1;
    logic              cs_s2;
    logic              cs_d;
    logic              sck_s1;
    logic              sck_s2;
    logic              sck_d;
    logic              active;
    logic [CNT_W-1:0]  falls;
    logic [RES_W-1:0]  shreg;
    ascp_link_t        link;
    logic              hold;
    logic              start;
    logic              abort;
    ascp_pmode_t       mode;
    logic [WAKE_W-1:0] wake;
  } ascp_core_t;

  localparam ascp_core_t CORE_RST = '{
    cs_s1: 1'b1, cs_s2: 1'b1, cs_d: 1'b1,
    sck_s1: 1'b1, sck_s2: 1'b1, sck_d: 1'b1,
    active: 1'b0, falls: '0, shreg: '0,
    link: '0, hold: 1'b0, start: 1'b0, abort: 1'b0,
    mode: PM_NORMAL, wake: '0
  };
endpackage : ascp_pkg

// ==== verilog/ascp_fifo.sv ====
`timescale 1ns/1ns
module ascp_fifo #(
  parameter int W = 12,
  parameter int D = 4
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         flush_i,
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  output logic              out_valid_o,
  output logic [W-1:0]      out_data_o,
  input  wire logic         out_ready_i
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [CW-1:0]       cnt;
  } ascp_fifo_st_t;

  ascp_fifo_st_t r_reg;
  ascp_fifo_st_t r_next;
  logic          push;
  logic          pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(D - 1)) ? '0 : p + 1'b1;
  endfunction : ptr_inc

  assign in_ready_o  = (r_reg.cnt != CW'(D));
  assign out_valid_o = (r_reg.cnt != '0);
  assign out_data_o  = r_reg.mem[r_reg.rp];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb begin
    r_next = r_reg;
    if (flush_i) begin
      r_next.wp  = '0;
      r_next.rp  = '0;
      r_next.cnt = '0;
    end else begin
      if (push) begin
        r_next.mem[r_reg.wp] = in_data_i;
        r_next.wp            = ptr_inc(r_reg.wp);
      end
      if (pop) begin
        r_next.rp = ptr_inc(r_reg.rp);
      end
      if (push && !pop) begin
        r_next.cnt = r_reg.cnt + 1'b1;
      end else if (pop && !push) begin
        r_next.cnt = r_reg.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end
endmodule : ascp_fifo

// ==== verilog/ascp_port.sv ====
`timescale 1ns/1ns
// Function
// RULE_01: chip select fall holds, samples, drives output
// RULE_02: conversion starts at fall, takes sixteen clocks
// RULE_03: back to track after thirteenth fall
// RULE_04: output floats on sixteenth falling edge
// RULE_05: early chip select rise aborts, floats output
// RULE_06: first zero at select fall, rest on falls
// RULE_07: last bit out on fifteenth fall
// RULE_08: slow master may sample on rising edges
// RULE_09: serial clock paces conversion and readout
// RULE_10: master waits 650 us after full wake
// RULE_11: master uses 8-clock frames for power-down
// RULE_12: master spaces chip select falls equally
// RULE_13: master runs clock idle high, phase zero
// RULE_14: rise in window two to ten powers down
// RULE_15: rise before second fall keeps power mode
// RULE_16: ten falls wake device, sixteen finish
// RULE_17: four zeros then twelve bits, MSB first
module ascp_port #(
  parameter int WAKE_CYCLES = ascp_pkg::WAKE_CYC
) (
  input  wire logic        CORE_CLK_I,
  input  wire logic        RST_I,
  input  wire logic        CS_N_I,
  input  wire logic        SCLK_I,
  output logic             SERIAL_RESULT_OUT_O,
  output logic             SERIAL_RESULT_OE_O,
  output logic             HOLD_O,
  output logic             CONV_START_O,
  output logic             CONV_ABORT_O,
  input  wire logic [11:0] CONV_DATA_I,
  input  wire logic        CONV_VALID_I,
  output logic             CONV_READY_O,
  output logic             PWR_PARTIAL_O,
  output logic             PWR_FULL_O,
  output logic             ANALOG_ON_O,
  output logic             WAKE_DONE_O
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  localparam logic [ascp_pkg::WAKE_W-1:0] WAKE_LOAD =
    ascp_pkg::WAKE_W'(WAKE_CYCLES);

  ascp_pkg::ascp_core_t             r_reg;
  ascp_pkg::ascp_core_t             r_next;
  logic                             cs_fall;
  logic                             cs_rise;
  logic                             sck_fall;
  logic                             sck_rise;
  logic                             fetch;
  logic                             fifo_valid;
  logic [ascp_pkg::RES_W-1:0]       fifo_data;

  // ----------------------------------------
  // power mode decode at frame end
  // ----------------------------------------
  function automatic ascp_pkg::ascp_pmode_t next_mode(
    input ascp_pkg::ascp_pmode_t cur,
    input logic [ascp_pkg::CNT_W-1:0] falls
  );
    if (falls < ascp_pkg::PD_LO) begin
      next_mode = cur; // RULE_15
    end else if (falls < ascp_pkg::PD_HI) begin
      next_mode = (cur == ascp_pkg::PM_NORMAL) ? // RULE_14
                  ascp_pkg::PM_PARTIAL : ascp_pkg::PM_FULL;
    end else begin
      next_mode = ascp_pkg::PM_NORMAL; // RULE_16
    end
  endfunction : next_mode

  // ----------------------------------------
  // edge detection on synchronised pins
  // ----------------------------------------
  // pins are async to the core clock; the serial clock must stay
  // well below a quarter of the core rate so no edge is missed
  assign cs_fall  = r_reg.cs_d && !r_reg.cs_s2;
  assign cs_rise  = !r_reg.cs_d && r_reg.cs_s2;
  assign sck_fall = r_reg.sck_d && !r_reg.sck_s2;
  assign sck_rise = !r_reg.sck_d && r_reg.sck_s2;
  assign fetch    = r_reg.active && sck_fall && !cs_rise &&
                    (r_reg.falls == ascp_pkg::FETCH_AT);

  // ----------------------------------------
  // result buffer
  // ----------------------------------------
  // flushed on every frame start so a word left over from an
  // aborted frame never leaks into the next one
  ascp_fifo #(
    .W (ascp_pkg::RES_W),
    .D (ascp_pkg::FIFO_D)
  ) u_fifo (
    .clk_i       (CORE_CLK_I),
    .rst_i       (RST_I),
    .flush_i     (cs_fall),
    .in_valid_i  (CONV_VALID_I),
    .in_data_i   (CONV_DATA_I),
    .in_ready_o  (CONV_READY_O),
    .out_valid_o (fifo_valid),
    .out_data_o  (fifo_data),
    .out_ready_i (fetch)
  );

  // ----------------------------------------
  // frame sequencer
  // ----------------------------------------
  always_comb begin
    r_next        = r_reg;
    r_next.start  = 1'b0;
    r_next.abort  = 1'b0;
    r_next.cs_s1  = CS_N_I;
    r_next.cs_s2  = r_reg.cs_s1;
    r_next.cs_d   = r_reg.cs_s2;
    r_next.sck_s1 = SCLK_I;
    r_next.sck_s2 = r_reg.sck_s1;
    r_next.sck_d  = r_reg.sck_s2;
    if (r_reg.wake != '0) begin
      r_next.wake = r_reg.wake - 1'b1;
    end
    if (cs_fall) begin
      r_next.active    = 1'b1;
      r_next.falls     = '0;
      r_next.hold      = 1'b1; // RULE_01
      r_next.link.oe   = 1'b1; // RULE_01
      r_next.link.dout = 1'b0; // RULE_06
      r_next.shreg     = '0;
      r_next.start     = 1'b1; // RULE_02
    end else if (r_reg.active && cs_rise) begin
      r_next.active  = 1'b0;
      r_next.link.oe = 1'b0; // RULE_05
      r_next.hold    = 1'b0;
      r_next.abort   = 1'b1; // RULE_05
      r_next.mode    = next_mode(r_reg.mode, r_reg.falls);
    end else if (r_reg.active && sck_fall) begin
      r_next.falls = r_reg.falls + 1'b1; // RULE_09
      if (r_next.falls == ascp_pkg::FRAME_END) begin
        r_next.active  = 1'b0; // RULE_02
        r_next.link.oe = 1'b0; // RULE_04
        r_next.mode    = next_mode(r_reg.mode, r_next.falls);
      end else if (r_next.falls == ascp_pkg::LEAD_ZERO) begin
        // an empty buffer means the core was late: send zeros
        r_next.link.dout = fifo_valid && fifo_data[ascp_pkg::RES_W-1]; // RULE_17
        r_next.shreg     = fifo_valid ? {fifo_data[ascp_pkg::RES_W-2:0], 1'b0} : '0;
      end else if (r_next.falls > ascp_pkg::LEAD_ZERO) begin
        r_next.link.dout = r_reg.shreg[ascp_pkg::RES_W-1]; // RULE_07
        r_next.shreg     = {r_reg.shreg[ascp_pkg::RES_W-2:0], 1'b0};
      end else begin
        r_next.link.dout = 1'b0; // RULE_06
      end
    end else if (r_reg.active && sck_rise &&
                 r_reg.falls >= ascp_pkg::TRACK_AFT) begin
      r_next.hold = 1'b0; // RULE_03
    end
    if (r_reg.mode == ascp_pkg::PM_FULL &&
        r_next.mode == ascp_pkg::PM_NORMAL) begin
      r_next.wake = WAKE_LOAD;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      r_reg <= ascp_pkg::CORE_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign SERIAL_RESULT_OUT_O = r_reg.link.dout;
  assign SERIAL_RESULT_OE_O  = r_reg.link.oe;
  assign HOLD_O              = r_reg.hold;
  assign CONV_START_O        = r_reg.start;
  assign CONV_ABORT_O        = r_reg.abort;
  assign PWR_PARTIAL_O       = (r_reg.mode == ascp_pkg::PM_PARTIAL);
  assign PWR_FULL_O          = (r_reg.mode == ascp_pkg::PM_FULL);
  assign ANALOG_ON_O         = (r_reg.mode == ascp_pkg::PM_NORMAL) ||
                               r_reg.active;
  assign WAKE_DONE_O         = (r_reg.wake == '0);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (RST_I);

  hold_on_fall_a: assert property ( // RULE_01
    cs_fall |=> (HOLD_O && SERIAL_RESULT_OE_O && CONV_START_O))
    else $error("select fall did not hold and drive");

  hold_keep_a: assert property ( // RULE_03
    (r_reg.active && r_reg.falls < ascp_pkg::TRACK_AFT && HOLD_O
     && !cs_rise) |=> HOLD_O)
    else $error("track resumed before thirteenth fall");

  track_back_a: assert property ( // RULE_03
    (r_reg.active && sck_rise && !cs_rise && !cs_fall &&
     r_reg.falls >= ascp_pkg::TRACK_AFT) |=> !HOLD_O)
    else $error("no return to track after thirteenth fall");

  float_end_a: assert property ( // RULE_04
    (r_reg.active && sck_fall && !cs_rise && !cs_fall &&
     r_reg.falls == ascp_pkg::LAST_BIT) |=> (!SERIAL_RESULT_OE_O && !r_reg.active))
    else $error("output not floated on sixteenth fall");

  abort_float_a: assert property ( // RULE_05
    (r_reg.active && cs_rise) |=> (!SERIAL_RESULT_OE_O && CONV_ABORT_O))
    else $error("early rise did not abort");

  lead_zero_a: assert property ( // RULE_06
    (SERIAL_RESULT_OE_O && r_reg.falls < ascp_pkg::LEAD_ZERO)
    |-> !SERIAL_RESULT_OUT_O)
    else $error("leading zero not zero");

  fall_pace_a: assert property ( // RULE_09
    $changed(SERIAL_RESULT_OUT_O) |-> $past(sck_fall || cs_fall))
    else $error("data changed off a falling edge");

  msb_first_a: assert property ( // RULE_17
    (fetch && !cs_fall && fifo_valid) |=>
    (SERIAL_RESULT_OUT_O == $past(fifo_data[ascp_pkg::RES_W-1])))
    else $error("result msb not first after zeros");

  glitch_keep_a: assert property ( // RULE_15
    (r_reg.active && cs_rise && r_reg.falls < ascp_pkg::PD_LO)
    |=> $stable(r_reg.mode))
    else $error("glitch changed power mode");

  pd_partial_a: assert property ( // RULE_14
    (r_reg.active && cs_rise && r_reg.falls >= ascp_pkg::PD_LO &&
     r_reg.falls < ascp_pkg::PD_HI && r_reg.mode == ascp_pkg::PM_NORMAL)
    |=> PWR_PARTIAL_O)
    else $error("window rise did not enter partial");

  pd_full_a: assert property ( // RULE_14
    (r_reg.active && cs_rise && r_reg.falls >= ascp_pkg::PD_LO &&
     r_reg.falls < ascp_pkg::PD_HI && r_reg.mode != ascp_pkg::PM_NORMAL)
    |=> PWR_FULL_O)
    else $error("window rise did not enter full");

  wake_up_a: assert property ( // RULE_16
    (r_reg.active && cs_rise && r_reg.falls >= ascp_pkg::PD_HI)
    |=> (!PWR_PARTIAL_O && !PWR_FULL_O))
    else $error("long frame did not wake device");

  frame_len_a: assert property ( // RULE_02
    (r_reg.active && sck_fall && !cs_rise &&
     r_reg.falls == ascp_pkg::LAST_BIT) |=> (ANALOG_ON_O && !SERIAL_RESULT_OE_O))
    else $error("frame did not complete at sixteen");

  // ----------------------------------------
  // frame bookkeeping checks
  // ----------------------------------------
  start_pulse_a: assert property ( // RULE_02
    CONV_START_O |=> !CONV_START_O)
    else $error("start pulse longer than one cycle");

  abort_pulse_a: assert property ( // RULE_05
    CONV_ABORT_O |=> !CONV_ABORT_O)
    else $error("abort pulse longer than one cycle");

  fall_count_a: assert property ( // RULE_09
    (r_reg.active && sck_fall && !cs_rise && !cs_fall)
    |=> (r_reg.falls == $past(r_reg.falls) + 5'h01))
    else $error("serial fall not counted");

  count_still_a: assert property ( // RULE_09
    (!sck_fall && !cs_fall) |=> $stable(r_reg.falls))
    else $error("fall count moved without a fall");

  oe_frame_a: assert property ( // RULE_04
    SERIAL_RESULT_OE_O == r_reg.active)
    else $error("output enable outside a frame");

  hold_idle_a: assert property ( // RULE_05
    !r_reg.active |-> !HOLD_O)
    else $error("held outside a frame");

  data_shift_a: assert property ( // RULE_07
    (r_reg.active && sck_fall && !cs_rise && !cs_fall &&
     r_reg.falls >= ascp_pkg::LEAD_ZERO && r_reg.falls < ascp_pkg::LAST_BIT)
    |=> (SERIAL_RESULT_OUT_O == $past(r_reg.shreg[ascp_pkg::RES_W-1])))
    else $error("result bit not shifted on a fall");

  pmode_onehot_a: assert property ( // RULE_14
    $onehot(r_reg.mode))
    else $error("power mode not one-hot");

  mode_at_end_a: assert property ( // RULE_14
    $changed(r_reg.mode) |-> $past(r_reg.active && (cs_rise ||
      (sck_fall && r_reg.falls == ascp_pkg::LAST_BIT))))
    else $error("power mode moved inside a frame");

  wake_load_a: assert property ( // RULE_16
    (PWR_FULL_O && r_reg.active && sck_fall && !cs_rise && !cs_fall &&
     r_reg.falls == ascp_pkg::LAST_BIT) |=> !WAKE_DONE_O)
    else $error("wake timer not started on full wake");

  wake_count_a: assert property ( // RULE_16
    (!WAKE_DONE_O && !(PWR_FULL_O && r_reg.active)) |=>
    (r_reg.wake == $past(r_reg.wake) - 1'b1))
    else $error("wake timer did not count down");
endmodule : ascp_port

// ==== dv/ascp_master.sv ====
`timescale 1ns/1ns
module ascp_master #(
  parameter int HALF = 8
) (
  input  wire logic clk_i,
  input  wire logic sdo_i,
  input  wire logic oe_i,
  input  wire logic hold_i,
  output logic      cs_n_o,
  output logic      sclk_o
);
  logic [15:0] got;
  logic        h13;
  logic        h14;
  logic        oe_lost;
  logic [15:0] got_r;

  initial begin
    cs_n_o  = 1'b1;
    sclk_o  = 1'b1;
    got     = '0;
    got_r   = '0;
    h13     = 1'b0;
    h14     = 1'b0;
    oe_lost = 1'b0;
  end

  task automatic hw(input int n);
    repeat (n) @(posedge clk_i);
  endtask : hw

  // ----------------------------------------
  // one frame of n clocks, capture on falls
  // ----------------------------------------
  // the clock only runs inside a frame; short frames end by raising select early
  task automatic frame(input int n);
    got     = '0;
    got_r   = '0;
    oe_lost = 1'b0;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    hw(HALF);
    for (int k = 1; k <= n; k++) begin
      @(negedge clk_i);
      got[16-k] = sdo_i;
      // slow-clock capture: first zero still taken before the first fall
      if (k == 1) got_r[15] = sdo_i;
      if (oe_i !== 1'b1) oe_lost = 1'b1;
      if (k == 13) h13 = hold_i;
      if (k == 14) h14 = hold_i;
      @(posedge clk_i);
      sclk_o <= 1'b0;
      hw(HALF);
      if (k < 16) got_r[15-k] = sdo_i;
      sclk_o <= 1'b1;
      hw(HALF);
    end
    cs_n_o <= 1'b1;
  endtask : frame
endmodule : ascp_master

// ==== dv/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
  localparam int WAKE = 20;
  logic        clk;
  logic        rst;
  logic [11:0] data;
  logic [11:0] next_word;
  logic        valid;
  logic        burst;
  logic        cs_n;
  logic        sclk;
  logic        out;
  logic        oe;
  logic        pin;
  logic        hold;
  logic        start;
  logic        abort;
  logic        ready;
  logic        ppart;
  logic        pfull;
  logic        aon;
  logic        wdone;
  int          bad_count;
  int          checked;
  int          start_cnt = 0;
  int          abort_cnt = 0;

  ascp_port #(.WAKE_CYCLES(WAKE)) uut (
    .CORE_CLK_I(clk), .RST_I(rst), .CS_N_I(cs_n), .SCLK_I(sclk),
    .SERIAL_RESULT_OUT_O(out), .SERIAL_RESULT_OE_O(oe), .HOLD_O(hold),
    .CONV_START_O(start), .CONV_ABORT_O(abort), .CONV_DATA_I(data),
    .CONV_VALID_I(valid), .CONV_READY_O(ready), .PWR_PARTIAL_O(ppart),
    .PWR_FULL_O(pfull), .ANALOG_ON_O(aon), .WAKE_DONE_O(wdone)
  );

  // released pin shows the inverse so a stale bit cannot pass
  assign pin = oe ? out : ~out;

  ascp_master u_m (
    .clk_i(clk), .sdo_i(pin), .oe_i(oe), .hold_i(hold), .cs_n_o(cs_n), .sclk_o(sclk)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------
  // analog core stand-in: one word per frame start, one per cycle while burst is set
  // ----------------------------------------
  always @(posedge clk) begin
    if (start) start_cnt++;
    if (abort) abort_cnt++;
    if (rst) begin
      valid <= 1'b0;
    end else if (start || burst) begin
      valid <= 1'b1;
      data  <= next_word;
    end else if (valid && ready) begin
      valid <= 1'b0;
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_full(input logic [11:0] w);
    int s0;
    s0 = start_cnt;
    next_word <= w;
    u_m.frame(16);
    // fixed tail keeps back-to-back select falls equally spaced
    cyc(6);
    chk("frame word", {4'h0, w}, u_m.got);
    chk("rise word", {4'h0, w}, u_m.got_r);
    chk("oe in frame", 16'h0000, {15'h0, u_m.oe_lost});
    chk("oe after", 16'h0000, {15'h0, oe});
    chk("hold at 13", 16'h0001, {15'h0, u_m.h13});
    chk("hold at 14", 16'h0000, {15'h0, u_m.h14});
    chk("starts", 16'(s0 + 1), 16'(start_cnt));
  endtask : t_full

  task automatic t_abort;
    int a0;
    a0 = abort_cnt;
    u_m.frame(12);
    cyc(6);
    chk("oe abort", 16'h0000, {15'h0, oe});
    chk("aborts", 16'(a0 + 1), 16'(abort_cnt));
    chk("hold abort", 16'h0000, {15'h0, hold});
    chk("mode late", 16'h0000, {14'h0, ppart, pfull});
  endtask : t_abort

  task automatic pmode(input int n, input logic [1:0] exp, input string what);
    u_m.frame(n);
    cyc(6);
    chk(what, {14'h0, exp}, {14'h0, ppart, pfull});
  endtask : pmode

  task automatic t_power;
    pmode(1, 2'b00, "glitch normal");
    pmode(8, 2'b10, "to partial");
    pmode(1, 2'b10, "glitch partial");
    pmode(8, 2'b01, "to full");
    chk("analog off", 16'h0000, {15'h0, aon});
    pmode(16, 2'b00, "wake");
    chk("wake pending", 16'h0000, {15'h0, wdone});
    cyc(WAKE + 2);
    chk("wake done", 16'h0001, {15'h0, wdone});
    t_full(12'hA5C);
  endtask : t_power

  task automatic t_fill;
    next_word <= 12'h3C9;
    burst     <= 1'b1;
    cyc(8);
    chk("fifo full", 16'h0000, {15'h0, ready});
    burst <= 1'b0;
    t_full(12'h3C9);
    chk("fifo room", 16'h0001, {15'h0, ready});
  endtask : t_fill

  initial begin
    bad_count = 0;
    checked   = 0;
    rst       = 1'b1;
    next_word = 12'h000;
    burst     = 1'b0;
    cyc(6);
    rst <= 1'b0;
    cyc(2);
    chk("reset outs", 16'h0007, {9'h0, oe, hold, ppart, pfull, aon, wdone, ready});
    t_full(12'hFFF);
    t_full(12'h001);
    t_abort();
    t_power();
    t_fill();
    tally_and_finish();
  end

  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    $display("BAD run length expected done seen hang");
    tally_and_finish();
  end
endmodule : tb_top
